// File: rtl/rps_pkg.sv
// Constants, types and register map of the reset pin sequencer
//------------------------------------------------------------------------------
// Overview of operation
// RULE_01 - Out of reset, other modules' pins become port inputs, alternate functions off.
// RULE_02 - Timer and serial pins inputs; waveform pins outputs; receive and debug keep function.
// RULE_03 - Outside reset must be held low; acting on it waits for bus end or timeout.
// RULE_04 - While reset is active, integration-unit pins stay high-impedance or inactive.
// RULE_05 - After a latched outside reset, drive pin low 512 cycles once outside lets go.
// RULE_06 - Internal reset drives pin at least 512 cycles, longer while request persists.
// RULE_07 - After a drive phase, release pin ten cycles, then sample; high starts reset processing.
// RULE_08 - A low sample drives another 512 cycles and repeats release-and-test until high.
// RULE_09 - At power-up, hold reset pin until oscillator loop locks, then 512 more cycles. Code waits for lock only with the synthesiser selected.
// RULE_10 - Other modules reset once clock runs and internal reset held four cycles.
// RULE_11 - Three-state control held ten cycles puts every output driver in high impedance.
// RULE_12 - With external clock source, float after ten external clock pulses following assertion.
// RULE_13 - Once floated, never resume; only power removal and restart recover.
// RULE_14 - Clock select level sampled during reset picks oscillator (high) or external clock.
// RULE_15 - One phase counter reloaded at each phase change; pin sampled via synchroniser.
//------------------------------------------------------------------------------
package rps_pkg;

  //----------------------------------------------------------------------------
  // Cycle counts
  //----------------------------------------------------------------------------
  localparam logic [9:0] DRIVE_LOAD      = 10'h1ff;  // 512 cycles, counted down to zero
  localparam logic [9:0] RELEASE_LOAD    = 10'h009;  // 10 cycles
  localparam logic [9:0] EXT_MIN_LOW     = 10'h003;  // Least low time before latching
  localparam logic [9:0] BUS_TIMEOUT     = 10'h03f;  // Bus monitor timeout
  localparam logic [2:0] MODRST_CYCLES   = 3'h4;
  localparam logic [3:0] TSC_CYCLES      = 4'ha;

  //----------------------------------------------------------------------------
  // Register map (byte addresses)
  //----------------------------------------------------------------------------
  localparam int         ADDR_W          = 8;
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] STATUS_OFS      = 8'h04;
  localparam logic [7:0] TIMER_CFG_OFS   = 8'h08;
  localparam logic [7:0] SERIAL_CFG_OFS  = 8'h0c;

  localparam int         CTRL_SWRST_BIT  = 0;
  localparam int         ST_STATE_LSB    = 0;
  localparam int         ST_PIN_BIT      = 3;
  localparam int         ST_SYNTH_BIT    = 4;
  localparam int         ST_FLOAT_BIT    = 5;
  localparam int         ST_MODRST_BIT   = 6;
  localparam int         ST_LOCK_BIT     = 7;
  localparam int         ST_RETEST_LSB   = 8;

  //----------------------------------------------------------------------------
  // Types
  //----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR, ST_RUN, ST_DEFER, ST_EXT_WAIT, ST_DRIVE, ST_RELEASE
  } rps_state_t;

  // Timer pins: [7:0] alternate enable, [15:8] direction, [17:16] waveform direction
  typedef struct packed {
    logic [1:0] waveDir;
    logic [7:0] portDir;
    logic [7:0] altEn;
  } rps_timer_cfg_t;

  // Serial pins: [7:0] alternate enable, [15:8] direction, [16] receive, [17] debug
  typedef struct packed {
    logic       debugDedicated;
    logic       rxDedicated;
    logic [7:0] portDir;
    logic [7:0] altEn;
  } rps_serial_cfg_t;

  localparam rps_timer_cfg_t  TIMER_CFG_RST  = '{waveDir: 2'h3, portDir: 8'h00, altEn: 8'h00};
  localparam rps_serial_cfg_t SERIAL_CFG_RST = '{debugDedicated: 1'b1, rxDedicated: 1'b1,
                                                 portDir: 8'h00, altEn: 8'h00};

endpackage

// File: rtl/rps_reset_pin_sequencer.sv
// Reset pin sequencer: drive/release/test of the open-drain reset pin, APB registers
`timescale 1ns/1ps
`default_nettype none
module rps_reset_pin_sequencer (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Open-drain reset pin
  input  wire logic                   resetPinIn,
  output logic                        resetPinOut,
  output logic                        resetPinOe,
  // Other pins and on-chip signals
  input  wire logic                   threeStateControl,
  input  wire logic                   clockSourceSelect,
  input  wire logic                   externalClockInput,
  input  wire logic                   pllLocked,
  input  wire logic                   internalResetReq,
  input  wire logic                   busIdle,
  output logic                        systemClockSynth,
  output logic                        simPinsInactive,
  output logic                        outputsFloat,
  output logic                        moduleReset,
  output logic                        resetExceptionStart,
  output rps_pkg::rps_timer_cfg_t     timerCfg,
  output rps_pkg::rps_serial_cfg_t    serialCfg
);

  //----------------------------------------------------------------------------
  // Input synchronisers
  //----------------------------------------------------------------------------
  logic pinHigh, tscSync, clkSelSync, extClkSync, lockSync;

  rps_sync3 #(.INIT(1'b1)) uPinSync (.clk(clk), .resetn(resetn), .din(resetPinIn),
                                     .dout(pinHigh)); // RULE_15
  rps_sync3 #(.INIT(1'b0)) uTscSync (.clk(clk), .resetn(resetn), .din(threeStateControl),
                                     .dout(tscSync));
  rps_sync3 #(.INIT(1'b1)) uSelSync (.clk(clk), .resetn(resetn), .din(clockSourceSelect),
                                     .dout(clkSelSync));
  rps_sync3 #(.INIT(1'b0)) uExtSync (.clk(clk), .resetn(resetn), .din(externalClockInput),
                                     .dout(extClkSync));
  rps_sync3 #(.INIT(1'b0)) uLockSync (.clk(clk), .resetn(resetn), .din(pllLocked),
                                      .dout(lockSync));

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  rps_pkg::rps_state_t      stateQ;
  logic [9:0]               phaseCntQ;
  logic [7:0]               retestCntQ;
  logic                     excStartQ;
  logic                     clkSynthQ;
  logic                     swResetQ;
  logic                     floatQ;
  logic [3:0]               tscCntQ;
  logic                     extClkPrevQ;
  logic [2:0]               modCntQ;
  rps_pkg::rps_timer_cfg_t  timerCfgQ;
  rps_pkg::rps_serial_cfg_t serialCfgQ;
  logic [31:0]              prdataQ;

  logic intReq;
  logic resetActive;
  logic phaseDone;
  logic apbWrite;
  logic mapped;

  assign intReq      = internalResetReq | swResetQ;
  assign resetActive = (stateQ != rps_pkg::ST_RUN);
  assign phaseDone   = (phaseCntQ == 10'h000);
  assign apbWrite    = psel & penable & pwrite;

  //----------------------------------------------------------------------------
  // Reset pin sequence
  //----------------------------------------------------------------------------
  // Frozen once the drivers have floated: nothing but power-on reset restarts it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stateQ     <= rps_pkg::ST_POR;
      phaseCntQ  <= 10'h000;
      retestCntQ <= 8'h00;
    end else if (!floatQ) begin // RULE_13
      case (stateQ)
        rps_pkg::ST_POR: begin
          if (!clkSynthQ || lockSync) begin // RULE_09
            stateQ    <= rps_pkg::ST_DRIVE;
            phaseCntQ <= rps_pkg::DRIVE_LOAD;
          end
        end
        rps_pkg::ST_RUN: begin
          if (!pinHigh) begin
            stateQ    <= rps_pkg::ST_DEFER;
            phaseCntQ <= 10'h000;
          end else if (intReq) begin // RULE_06
            stateQ    <= rps_pkg::ST_DRIVE;
            phaseCntQ <= rps_pkg::DRIVE_LOAD;
          end
        end
        rps_pkg::ST_DEFER: begin
          // Let a pending write finish before reset takes hold; a short glitch is dropped
          if (pinHigh) begin // RULE_03
            stateQ <= rps_pkg::ST_RUN;
          end else if (phaseCntQ >= rps_pkg::EXT_MIN_LOW &&
                       (busIdle || phaseCntQ >= rps_pkg::BUS_TIMEOUT)) begin // RULE_03
            stateQ    <= rps_pkg::ST_EXT_WAIT;
            phaseCntQ <= 10'h000;
          end else begin
            phaseCntQ <= phaseCntQ + 10'h001;
          end
        end
        rps_pkg::ST_EXT_WAIT: begin
          if (pinHigh) begin // RULE_05
            stateQ    <= rps_pkg::ST_DRIVE;
            phaseCntQ <= rps_pkg::DRIVE_LOAD;
          end
        end
        rps_pkg::ST_DRIVE: begin
          if (!phaseDone) begin
            phaseCntQ <= phaseCntQ - 10'h001;
          end else if (!intReq) begin // RULE_06
            stateQ    <= rps_pkg::ST_RELEASE; // RULE_07
            phaseCntQ <= rps_pkg::RELEASE_LOAD;
          end
        end
        rps_pkg::ST_RELEASE: begin
          if (!phaseDone) begin
            phaseCntQ <= phaseCntQ - 10'h001;
          end else if (pinHigh) begin // RULE_07
            stateQ <= rps_pkg::ST_RUN;
          end else begin // RULE_08
            stateQ     <= rps_pkg::ST_DRIVE;
            phaseCntQ  <= rps_pkg::DRIVE_LOAD;
            retestCntQ <= retestCntQ + 8'h01;
          end
        end
        default: begin
          stateQ    <= rps_pkg::ST_POR;
          phaseCntQ <= 10'h000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      excStartQ <= 1'b0;
    end else begin
      excStartQ <= !floatQ && stateQ == rps_pkg::ST_RELEASE && phaseDone && pinHigh; // RULE_07
    end
  end

  // Clock source follows the select level while the reset sequence runs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clkSynthQ <= 1'b1;
    end else if (resetActive) begin
      clkSynthQ <= clkSelSync; // RULE_14
    end
  end

  // Software request is set by a write and consumed when driving starts; set wins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      swResetQ <= 1'b0;
    end else if (apbWrite && paddr == rps_pkg::CTRL_OFS && pwdata[rps_pkg::CTRL_SWRST_BIT]) begin
      swResetQ <= 1'b1;
    end else if (stateQ == rps_pkg::ST_DRIVE) begin
      swResetQ <= 1'b0;
    end
  end

  //----------------------------------------------------------------------------
  // Three-state control
  //----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      extClkPrevQ <= 1'b0;
    end else begin
      extClkPrevQ <= extClkSync;
    end
  end

  // External pulses are only seen if no faster than a quarter of clk
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tscCntQ <= 4'h0;
    end else if (!tscSync) begin
      tscCntQ <= 4'h0;
    end else if (tscCntQ != rps_pkg::TSC_CYCLES) begin
      if (clkSynthQ || (extClkSync && !extClkPrevQ)) begin // RULE_12
        tscCntQ <= tscCntQ + 4'h1; // RULE_11
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      floatQ <= 1'b0;
    end else if (tscCntQ == rps_pkg::TSC_CYCLES) begin
      floatQ <= 1'b1; // RULE_13
    end
  end

  //----------------------------------------------------------------------------
  // Module reset and pin defaults
  //----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || !resetActive) begin
      modCntQ <= 3'h0;
    end else if (modCntQ != rps_pkg::MODRST_CYCLES) begin
      modCntQ <= modCntQ + 3'h1; // RULE_10
    end
  end

  assign moduleReset = resetActive && (modCntQ == rps_pkg::MODRST_CYCLES); // RULE_10

  always_ff @(posedge clk) begin
    if (!resetn || moduleReset) begin
      timerCfgQ  <= rps_pkg::TIMER_CFG_RST;  // RULE_01 RULE_02
      serialCfgQ <= rps_pkg::SERIAL_CFG_RST; // RULE_01 RULE_02
    end else if (apbWrite && paddr == rps_pkg::TIMER_CFG_OFS) begin
      timerCfgQ  <= pwdata[17:0];
    end else if (apbWrite && paddr == rps_pkg::SERIAL_CFG_OFS) begin
      serialCfgQ <= pwdata[17:0];
    end
  end

  //----------------------------------------------------------------------------
  // APB slave: zero wait states, read data captured in the setup cycle
  //----------------------------------------------------------------------------
  always_comb begin
    case (paddr)
      rps_pkg::CTRL_OFS, rps_pkg::STATUS_OFS,
      rps_pkg::TIMER_CFG_OFS, rps_pkg::SERIAL_CFG_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdataQ <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdataQ <= 32'h0000_0000;
      case (paddr)
        rps_pkg::CTRL_OFS: prdataQ[rps_pkg::CTRL_SWRST_BIT] <= swResetQ;
        rps_pkg::STATUS_OFS: begin
          prdataQ[rps_pkg::ST_STATE_LSB +: 3]  <= stateQ;
          prdataQ[rps_pkg::ST_PIN_BIT]         <= pinHigh;
          prdataQ[rps_pkg::ST_SYNTH_BIT]       <= clkSynthQ;
          prdataQ[rps_pkg::ST_FLOAT_BIT]       <= floatQ;
          prdataQ[rps_pkg::ST_MODRST_BIT]      <= moduleReset;
          prdataQ[rps_pkg::ST_LOCK_BIT]        <= lockSync;
          prdataQ[rps_pkg::ST_RETEST_LSB +: 8] <= retestCntQ;
        end
        rps_pkg::TIMER_CFG_OFS:  prdataQ[17:0] <= timerCfgQ;
        rps_pkg::SERIAL_CFG_OFS: prdataQ[17:0] <= serialCfgQ;
        default: prdataQ <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata  = prdataQ;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  //----------------------------------------------------------------------------
  // Pin outputs
  //----------------------------------------------------------------------------
  assign resetPinOut = 1'b0;
  assign resetPinOe  = !floatQ && (stateQ == rps_pkg::ST_POR ||
                                   stateQ == rps_pkg::ST_DRIVE); // RULE_05 RULE_11
  assign simPinsInactive     = resetActive | floatQ; // RULE_04
  assign outputsFloat        = floatQ;               // RULE_11
  assign systemClockSynth    = clkSynthQ;
  assign resetExceptionStart = excStartQ;
  assign timerCfg            = timerCfgQ;
  assign serialCfg           = serialCfgQ;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  drive_load_a: assert property ((stateQ != rps_pkg::ST_DRIVE) ##1 // RULE_05
      (stateQ == rps_pkg::ST_DRIVE) |-> phaseCntQ == 10'h1ff && resetPinOe)
    else $error("drive phase did not start at 512");
  release_load_a: assert property ($rose(stateQ == rps_pkg::ST_RELEASE) // RULE_07
      |-> phaseCntQ == 10'h009 && !resetPinOe)
    else $error("release phase not ten cycles high impedance");
  drive_end_a: assert property ((stateQ == rps_pkg::ST_DRIVE && phaseDone // RULE_06
      && !intReq && !floatQ) |=> stateQ == rps_pkg::ST_RELEASE)
    else $error("drive phase did not end in release");
  int_hold_a: assert property ((stateQ == rps_pkg::ST_DRIVE && phaseDone // RULE_06
      && intReq) |=> stateQ == rps_pkg::ST_DRIVE && resetPinOe)
    else $error("pin released while internal request active");
  retest_low_a: assert property ((stateQ == rps_pkg::ST_RELEASE && phaseDone // RULE_08
      && !pinHigh && !floatQ) |=> stateQ == rps_pkg::ST_DRIVE ##1 phaseCntQ == 10'h1fe)
    else $error("low sample did not restart drive");
  retest_high_a: assert property ((stateQ == rps_pkg::ST_RELEASE && phaseDone // RULE_07
      && pinHigh && !floatQ) |=> resetExceptionStart && !resetActive)
    else $error("high sample did not start exception");
  por_lock_a: assert property ((stateQ == rps_pkg::ST_POR && clkSynthQ // RULE_09
      && !lockSync) |=> stateQ == rps_pkg::ST_POR && resetPinOe)
    else $error("reset released before lock");
  // The counter restarts on resetn too, so the count starts with the first released edge
  mod_reset_a: assert property ((resetn && resetActive) [*5] |-> moduleReset) // RULE_10
    else $error("modules not reset after four cycles");
  pin_default_a: assert property (moduleReset |=> timerCfg.waveDir == 2'h3 // RULE_01
      && timerCfg.altEn == 8'h00 && serialCfg.portDir == 8'h00 && serialCfg.rxDedicated)
    else $error("pin defaults not applied");
  float_sticky_a: assert property (floatQ |=> floatQ && outputsFloat // RULE_13
      && !resetPinOe && $stable(stateQ))
    else $error("floated drivers resumed");
  tsc_float_a: assert property ((tscCntQ == 4'h9 && tscSync && clkSynthQ) // RULE_11
      |=> ##1 outputsFloat)
    else $error("three-state control did not float drivers");
  sim_inactive_a: assert property (resetActive |-> // RULE_04
      simPinsInactive && !resetExceptionStart)
    else $error("integration pins active during reset");

endmodule
`default_nettype wire

// File: rtl/rps_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module rps_sync3 #(
  parameter logic INIT = 1'b1
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);
  logic s1Q, s2Q, s3Q, outQ;

  // First stage feeds only the second one
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1Q <= INIT;
      s2Q <= INIT;
      s3Q <= INIT;
    end else begin
      s1Q <= din;
      s2Q <= s1Q;
      s3Q <= s2Q;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      outQ <= INIT;
    end else if (s2Q == s3Q) begin
      outQ <= s3Q;
    end
  end

  assign dout = outQ;
endmodule
`default_nettype wire

// File: verif/rps_reset_line_model.sv
// Board side of the reset line: pull-up plus other devices that may hold it low
`timescale 1ns/1ps
`default_nettype none
module rps_reset_line_model (
  input  wire logic dutOe,
  input  wire logic holdLow,
  output logic      pinLevel
);
  //----------------------------------------------------------------------------
  // Wired-AND line
  //----------------------------------------------------------------------------
  // The pull-up wins only when nobody pulls, so a released line reads high
  assign pinLevel = !(dutOe || holdLow);
endmodule
`default_nettype wire

// File: verif/tb_rps_reset_pin_sequencer.sv
// Self-checking testbench for the reset pin sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_rps_reset_pin_sequencer;
  logic                     clk = 1'b0;
  logic                     resetn = 1'b0;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [7:0]               paddr = 8'h00;
  logic [31:0]              pwdata = 32'h0;
  logic [31:0]              prdata;
  logic [31:0]              rd;
  logic                     pready, pslverr, pinIn, pinOe, pinOut, err;
  logic                     three_state_control = 1'b0;
  logic                     clkSel = 1'b1;
  logic                     extClk = 1'b0;
  logic                     locked = 1'b0;
  logic                     intReq = 1'b0;
  logic                     busIdle = 1'b1;
  logic                     holdLow = 1'b0;
  logic                     synth, pinsInactive, flt, modRst, excStart;
  rps_pkg::rps_timer_cfg_t  timerCfg;
  rps_pkg::rps_serial_cfg_t serialCfg;
  int                       n_errors = 0;
  int                       n_tests = 0;
  int                       cyc = 0;
  int                       n;

  always #50 clk = ~clk;

  rps_reset_pin_sequencer u_rps_reset_pin_sequencer (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .resetPinIn(pinIn), .resetPinOut(pinOut), .resetPinOe(pinOe), .threeStateControl(three_state_control),
    .clockSourceSelect(clkSel), .externalClockInput(extClk), .pllLocked(locked),
    .internalResetReq(intReq), .busIdle(busIdle), .systemClockSynth(synth),
    .simPinsInactive(pinsInactive), .outputsFloat(flt), .moduleReset(modRst),
    .resetExceptionStart(excStart), .timerCfg(timerCfg), .serialCfg(serialCfg));

  rps_reset_line_model u_rps_reset_line_model (
    .dutOe(pinOe), .holdLow(holdLow), .pinLevel(pinIn));

  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  task automatic wrap_up();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under 10000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chkv(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkr(input int c, input int lo, input int hi);
    n_tests++;
    if (c < lo || c > hi) begin
      n_errors++;
      $display("MISMATCH %0t count %0d outside %0d..%0d", $time, c, lo, hi);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: sig = pinOe;
      1: sig = excStart;
      default: sig = flt;
    endcase
  endfunction

  task automatic waitOn(input int k, input logic v, output int c);
    c = 0;
    while (sig(k) !== v && c < 3000) begin
      @(posedge clk);
      c++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Power restart of the whole board; the only way out of a float
  task automatic doReset(input logic sel);
    resetn <= 1'b0;
    clkSel <= sel;
    three_state_control <= 1'b0;
    intReq <= 1'b0;
    repeat (6) @(posedge clk);
    chkv(pinOe, 1);
    chkv(pinsInactive, 1);
    chkv(flt, 0);
    chkv(pinOut, 0);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    chkv(modRst, 0);
    repeat (4) @(posedge clk);
    chkv(modRst, 1);
  endtask

  //----------------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------------
  task automatic por();
    repeat (40) @(posedge clk);
    chkv(pinOe, 1);
    chkv(32'(timerCfg), 32'h30000);
    chkv(32'(serialCfg), 32'h30000);
    locked <= 1'b1;
    waitOn(0, 1'b0, n);
    chkr(n, 512, 522);
    waitOn(1, 1'b1, n);
    chkr(n, 10, 13);
    chkv(modRst, 0);
    chkv(synth, 1);
    chkv(pinsInactive, 0);
  endtask

  task automatic regs();
    apb(1'b0, rps_pkg::STATUS_OFS, 32'h0);
    chkv(rd[4:0], 5'h19);
    apb(1'b1, rps_pkg::TIMER_CFG_OFS, 32'h000155aa);
    apb(1'b0, rps_pkg::TIMER_CFG_OFS, 32'h0);
    chkv(rd, 32'h155aa);
    apb(1'b0, 8'h10, 32'h0);
    chkv(rd, 32'h0);
    chkv({31'h0, err}, 32'h1);
    apb(1'b1, rps_pkg::CTRL_OFS, 32'h1);
    waitOn(0, 1'b1, n);
    chkr(n, 0, 4);
    repeat (10) @(posedge clk);
    chkv(32'(timerCfg), 32'h30000);
    waitOn(0, 1'b0, n);
    chkr(n, 498, 506);
    waitOn(1, 1'b1, n);
    chkr(n, 10, 13);
  endtask

  task automatic retest();
    intReq <= 1'b1;
    @(posedge clk);
    intReq <= 1'b0;
    waitOn(0, 1'b1, n);
    holdLow <= 1'b1;
    waitOn(0, 1'b0, n);
    chkr(n, 509, 515);
    waitOn(0, 1'b1, n);
    chkr(n, 9, 14);
    apb(1'b0, rps_pkg::STATUS_OFS, 32'h0);
    chkv(rd[15:8], 8'h01);
    holdLow <= 1'b0;
    waitOn(0, 1'b0, n);
    chkr(n, 500, 515);
    waitOn(1, 1'b1, n);
    chkr(n, 10, 13);
    intReq <= 1'b1;
    repeat (800) @(posedge clk);
    chkv(pinOe, 1);
    intReq <= 1'b0;
    waitOn(0, 1'b0, n);
    chkr(n, 0, 4);
    waitOn(1, 1'b1, n);
    chkr(n, 10, 13);
  endtask

  task automatic extRst();
    holdLow <= 1'b1;
    @(posedge clk);
    holdLow <= 1'b0;
    repeat (40) @(posedge clk);
    chkv(pinOe, 0);
    busIdle <= 1'b0;
    holdLow <= 1'b1;
    repeat (100) @(posedge clk);
    chkv(pinOe, 0);
    holdLow <= 1'b0;
    busIdle <= 1'b1;
    waitOn(0, 1'b1, n);
    chkr(n, 1, 8);
    waitOn(0, 1'b0, n);
    chkr(n, 511, 514);
    waitOn(1, 1'b1, n);
    chkr(n, 10, 13);
  endtask

  task automatic tscTest();
    three_state_control <= 1'b1;
    repeat (9) @(posedge clk);
    chkv(flt, 0);
    waitOn(2, 1'b1, n);
    chkr(n, 1, 10);
    intReq <= 1'b1;
    repeat (30) @(posedge clk);
    chkv({flt, pinOe}, 2'b10);
    doReset(1'b0);
    locked <= 1'b0;
    waitOn(1, 1'b1, n);
    chkr(n, 515, 535);
    chkv(synth, 0);
    three_state_control <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      if (i == 9) begin
        chkv(flt, 0);
      end
      extClk <= 1'b1;
      repeat (5) @(posedge clk);
      extClk <= 1'b0;
      repeat (5) @(posedge clk);
    end
    waitOn(2, 1'b1, n);
    chkr(n, 0, 10);
  endtask

  initial begin
    doReset(1'b1);
    por();
    regs();
    retest();
    extRst();
    tscTest();
    wrap_up();
  end
endmodule
`default_nettype wire
